//--- rtl/port_pin_ctrl_pkg.sv
// Purpose: shared widths, reset values and pin bundles for the port pin control block
// Assumes: direction bit set means output, pullup select bit set means pullup wanted
// Notes: port widths follow the largest package option
package port_pin_ctrl_pkg;
    localparam int ALPHA_W = 4;
    localparam int BRAVO_W = 6;
    localparam int CHARLIE_W = 2;
    localparam int DELTA_W = 7;
    localparam int ECHO_W = 2;
    // delta field positions
    localparam int DELTA_SPI_LSB = 0;
    localparam int DELTA_SPI_W = 4;
    localparam int DELTA_TMR_LSB = 4;
    localparam int DELTA_TMR_W = 3;
    // echo field positions
    localparam int ECHO_TX_BIT = 0;
    localparam int ECHO_RX_BIT = 1;
    // reset values
    localparam logic [ALPHA_W-1:0] ALPHA_PU_RST = 4'h0;
    localparam logic [CHARLIE_W-1:0] CHARLIE_PU_RST = 2'h0;
    localparam logic [DELTA_W-1:0] DELTA_PU_RST = 7'h00;
    localparam logic [ALPHA_W-1:0] ALPHA_KEY_RST = 4'h0;
    localparam logic [BRAVO_W-1:0] BRAVO_ADC_RST = 6'h00;
    localparam logic [DELTA_TMR_W-1:0] DELTA_TMR_RST = 3'h0;
    localparam logic SPI_RST = 1'b0;
    localparam logic SCI_RST = 1'b0;

    // function assignment bundle
    typedef struct packed {
        logic [ALPHA_W-1:0] keypad_wake_function;
        logic [BRAVO_W-1:0] adc_select;
        logic spi_enable;
        logic [DELTA_TMR_W-1:0] timer_select;
        logic sci_enable;
    } func_sel_type;

    // pullup enables per port
    typedef struct packed {
        logic [ALPHA_W-1:0] port_alpha_bits;
        logic [BRAVO_W-1:0] port_bravo_bits;
        logic [CHARLIE_W-1:0] port_charlie_bits;
        logic [DELTA_W-1:0] port_delta_bits;
    } pullup_en_type;
endpackage

//--- rtl/port_pin_ctrl.sv
// Purpose: pullup decision, function takeover flags and reset pin drive for the ports
// Assumes: all control inputs come from logic on clk_sys_in; reset pin is asynchronous
// Notes: reset pin input passes three flops and counts once the last two agree
`timescale 1ns/1ps

// Function
// - alpha charlie delta inputs get selected pullup
// - output bits never get pullup, except alpha bits forced on by keypad wake
// - one pullup select bit per alpha, charlie and delta port bit
// - keypad wake bits force alpha pullup on
// - spi timer bits keep own pullup select
// - bravo port never has pullup
// - any alpha bits may be keypad inputs
// - bravo bits may become adc inputs
// - delta low spi, upper bits per timer
// - echo bits may become sci pins
// - low reset pin holds device in reset
// - internal reset source drives pin low
// - pullup selects cleared at reset
module port_pin_ctrl
    import port_pin_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // direction controls
    input wire logic [ALPHA_W-1:0] alpha_dir_in,
    input wire logic [CHARLIE_W-1:0] charlie_dir_in,
    input wire logic [DELTA_W-1:0] delta_dir_in,
    // pullup select writes
    input wire logic pullup_wr_in,
    input wire logic [ALPHA_W-1:0] port_alpha_pullup_select_in,
    input wire logic [CHARLIE_W-1:0] charlie_pullup_select_in,
    input wire logic [DELTA_W-1:0] delta_pullup_select_in,
    // function assignment writes
    input wire logic func_wr_in,
    input wire func_sel_type func_sel_in,
    // reset pin and internal reset sources
    input wire logic reset_pin_in,
    input wire logic internal_reset_in,
    // pullup enables
    output pullup_en_type pullup_en_out,
    // stored selections and takeover flags
    output logic [ALPHA_W-1:0] alpha_pullup_sel_out,
    output logic [CHARLIE_W-1:0] charlie_pullup_sel_out,
    output logic [DELTA_W-1:0] delta_pullup_sel_out,
    output func_sel_type func_sel_out,
    output logic [DELTA_W-1:0] delta_periph_owned_out,
    output logic [ECHO_W-1:0] echo_sci_owned_out,
    // reset pin drive and device reset
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    output logic device_reset_out
);

    logic [ALPHA_W-1:0] alpha_pu_reg;
    logic [CHARLIE_W-1:0] charlie_pu_reg;
    logic [DELTA_W-1:0] delta_pu_reg;
    func_sel_type func_reg;
    logic [2:0] pin_sync_reg;
    logic pin_low_reg;
    pullup_en_type pullup_reg;
    logic [DELTA_W-1:0] owned_reg;
    logic [ECHO_W-1:0] echo_reg;
    logic drive_reg;

    wire [ALPHA_W-1:0] alpha_pu_wire;
    wire [CHARLIE_W-1:0] charlie_pu_wire;
    wire [DELTA_W-1:0] delta_pu_wire;
    wire [DELTA_W-1:0] owned_wire;
    wire pin_agree;

    // pullup only on input bits that ask for it
    function automatic logic [7:0] input_pullup(input logic [7:0] dir, input logic [7:0] sel);
        input_pullup = ~dir & sel;
    endfunction

    // pullup decision per port
    assign alpha_pu_wire = ALPHA_W'(input_pullup({4'h0, alpha_dir_in}, {4'h0, alpha_pu_reg}))
        | func_reg.keypad_wake_function;
    assign charlie_pu_wire = CHARLIE_W'(input_pullup({6'h00, charlie_dir_in},
        {6'h00, charlie_pu_reg}));
    assign delta_pu_wire = DELTA_W'(input_pullup({1'b0, delta_dir_in},
        {1'b0, delta_pu_reg}));
    assign owned_wire = {func_reg.timer_select, {DELTA_SPI_W{func_reg.spi_enable}}};
    assign pin_agree = pin_sync_reg[2] == pin_sync_reg[1];

    // per-bit pullup selections, cleared at reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            alpha_pu_reg <= ALPHA_PU_RST;
            charlie_pu_reg <= CHARLIE_PU_RST;
            delta_pu_reg <= DELTA_PU_RST;
        end else if (pullup_wr_in) begin
            alpha_pu_reg <= port_alpha_pullup_select_in;
            charlie_pu_reg <= charlie_pullup_select_in;
            delta_pu_reg <= delta_pullup_select_in;
        end
    end

    // function assignments
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            func_reg <= '{ALPHA_KEY_RST, BRAVO_ADC_RST, SPI_RST, DELTA_TMR_RST, SCI_RST};
        end else if (func_wr_in) begin
            func_reg <= func_sel_in;
        end
    end

    // registered pullup enables and takeover flags
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pullup_reg <= '0;
            owned_reg <= '0;
            echo_reg <= '0;
        end else begin
            pullup_reg <= '{alpha_pu_wire, {BRAVO_W{1'b0}}, charlie_pu_wire,
                delta_pu_wire};
            owned_reg <= owned_wire;
            echo_reg <= {ECHO_W{func_reg.sci_enable}};
        end
    end

    // reset pin synchroniser, runs through reset so a held pin is seen
    always_ff @(posedge clk_sys_in) begin
        pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_in};
        if (pin_agree) begin
            pin_low_reg <= ~pin_sync_reg[2];
        end
        drive_reg <= internal_reset_in;
    end

    assign pullup_en_out = pullup_reg;
    assign alpha_pullup_sel_out = alpha_pu_reg;
    assign charlie_pullup_sel_out = charlie_pu_reg;
    assign delta_pullup_sel_out = delta_pu_reg;
    assign func_sel_out = func_reg;
    assign delta_periph_owned_out = owned_reg;
    assign echo_sci_owned_out = echo_reg;
    // open drain style drive of the reset pin
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_out = drive_reg;
    assign device_reset_out = pin_low_reg | ~rst_b_in;

    // pullup decision checks, one cycle behind the inputs they were built from
    chk_out_no_pullup: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) && $past(delta_dir_in[0]) |-> !pullup_en_out.port_delta_bits[0])
        else $error("output delta bit has pullup");
    chk_charlie_out: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) && $past(charlie_dir_in[0]) |-> !pullup_en_out.port_charlie_bits[0])
        else $error("output charlie bit has pullup");
    chk_alpha_out_off: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) && $past(alpha_dir_in[1]) && !$past(func_reg.keypad_wake_function[1])
        |-> !pullup_en_out.port_alpha_bits[1])
        else $error("output alpha bit has pullup");
    chk_in_pullup: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) && !$past(charlie_dir_in[1]) && $past(charlie_pu_reg[1])
        |-> pullup_en_out.port_charlie_bits[1])
        else $error("selected input pullup missing");
    chk_alpha_pullup: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) && !$past(alpha_dir_in[0]) && $past(alpha_pu_reg[0])
        |-> pullup_en_out.port_alpha_bits[0])
        else $error("selected alpha pullup missing");
    chk_key_force: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) && $past(func_reg.keypad_wake_function[2])
        |-> pullup_en_out.port_alpha_bits[2])
        else $error("keypad pullup not forced");
    chk_bravo_none: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        pullup_en_out.port_bravo_bits == 6'h00)
        else $error("bravo pullup enabled");
    chk_spi_honour: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) && $past(func_reg.spi_enable) && !$past(delta_dir_in[1])
        |-> pullup_en_out.port_delta_bits[1] == $past(delta_pu_reg[1]))
        else $error("spi bit pullup not from select");

    // stored selections load on their write strobe and clear on reset
    chk_sel_load: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        pullup_wr_in |=> delta_pullup_sel_out == $past(delta_pullup_select_in)
        && alpha_pullup_sel_out == $past(port_alpha_pullup_select_in))
        else $error("pullup select not stored");
    chk_sel_clear: assert property (@(posedge clk_sys_in)
        !rst_b_in |=> alpha_pu_reg == ALPHA_PU_RST && charlie_pu_reg == CHARLIE_PU_RST
        && delta_pu_reg == DELTA_PU_RST)
        else $error("pullup select not cleared");
    chk_func_load: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        func_wr_in |=> func_sel_out == $past(func_sel_in))
        else $error("function assignment not stored");

    // takeover flags follow the stored function assignments
    chk_timer_own: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> delta_periph_owned_out[6:4] == $past(func_reg.timer_select))
        else $error("timer takeover wrong");
    chk_spi_own: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in)
        |-> delta_periph_owned_out[3:0] == {DELTA_SPI_W{$past(func_reg.spi_enable)}})
        else $error("spi takeover wrong");
    chk_sci_own: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> echo_sci_owned_out == {ECHO_W{$past(func_reg.sci_enable)}})
        else $error("sci takeover wrong");

    // reset pin drive and device reset
    chk_pin_drive: assert property (@(posedge clk_sys_in)
        internal_reset_in |=> reset_pin_oe_out && !reset_pin_out)
        else $error("reset pin not driven");
    chk_pin_release: assert property (@(posedge clk_sys_in)
        !internal_reset_in |=> !reset_pin_oe_out)
        else $error("reset pin driven without source");
    chk_pin_reset: assert property (@(posedge clk_sys_in)
        !reset_pin_in [*4] |=> device_reset_out)
        else $error("held pin did not reset");
    chk_sys_reset: assert property (@(posedge clk_sys_in)
        !rst_b_in |-> device_reset_out)
        else $error("system reset not passed on");

    // main scenarios
    cov_key: cover property (@(posedge clk_sys_in) pullup_en_out.port_alpha_bits == 4'hf);
    cov_pin: cover property (@(posedge clk_sys_in) $rose(device_reset_out));
    cov_sci: cover property (@(posedge clk_sys_in) echo_sci_owned_out == 2'h3);
    cov_timer: cover property (@(posedge clk_sys_in) delta_periph_owned_out[6:4] == 3'h7);
    cov_ext_pin: cover property (@(posedge clk_sys_in)
        rst_b_in && device_reset_out && !reset_pin_oe_out);

endmodule // port_pin_ctrl

//--- sim/board_model.sv
// Purpose: board side of the reset pin, a pull-up plus an optional external low drive
// Assumes: the device only ever drives the pin low, never high
// Notes: the pull-up wins whenever nobody pulls the line low
`timescale 1ns/1ps
module board_model (
    // device side of the pin
    input wire logic drive_en_in,
    input wire logic drive_val_in,
    // board side of the pin
    input wire logic ext_low_in,
    output logic pin_level_out
);
    // wired level of device driver, board switch and pull-up
    assign pin_level_out = ((drive_en_in == 1'b1) && (drive_val_in == 1'b0)) ? 1'b0 :
        (ext_low_in ? 1'b0 : 1'b1);
endmodule // board_model

//--- sim/tb.sv
// Purpose: self-checking bench for the port pin control block
// Assumes: inputs change on the falling clock edge
// Notes: pullup enables settle two cycles after a write
`timescale 1ns/1ps
module tb;
    import port_pin_ctrl_pkg::*;
    typedef struct packed {
        logic [3:0] da, sa;
        logic [1:0] dc, sc;
        logic [6:0] dd, sd;
        func_sel_type f;
        logic [3:0] ea;
        logic [1:0] ec;
        logic [6:0] ed;
    } row_type;
    logic clk_sys_in = 1'b0, rst_b_in = 1'b0, pullup_wr_in = 1'b0, func_wr_in = 1'b0;
    logic internal_reset_in = 1'b0, ext_low = 1'b0, pin_level;
    logic [3:0] alpha_dir_in = 4'h0, alpha_sel = 4'h0;
    logic [1:0] charlie_dir_in = 2'h0, charlie_sel = 2'h0, echo_owned;
    logic [6:0] delta_dir_in = 7'h00, delta_sel = 7'h00, delta_owned;
    func_sel_type func_sel_in = '0, func_sel_out;
    pullup_en_type pullup_en_out;
    logic [3:0] a_sel_out;
    logic [1:0] c_sel_out;
    logic [6:0] d_sel_out;
    logic pin_out, pin_oe, dev_rst;
    int miscompares = 0, n_checks = 0;
    row_type rows [6] = '{
        '{4'h0, 4'hf, 2'h0, 2'h3, 7'h00, 7'h7f, '{4'h0, 6'h00, 1'b0, 3'h0, 1'b0}, 4'hf, 2'h3, 7'h7f},
        '{4'hf, 4'hf, 2'h3, 2'h3, 7'h7f, 7'h7f, '{4'h0, 6'h00, 1'b0, 3'h0, 1'b0}, 4'h0, 2'h0, 7'h00},
        '{4'h5, 4'hf, 2'h1, 2'h3, 7'h55, 7'h7f, '{4'h0, 6'h3f, 1'b0, 3'h7, 1'b0}, 4'ha, 2'h2, 7'h2a},
        '{4'h0, 4'h5, 2'h0, 2'h2, 7'h00, 7'h2a, '{4'h0, 6'h00, 1'b1, 3'h0, 1'b1}, 4'h5, 2'h2, 7'h2a},
        '{4'hf, 4'h0, 2'h0, 2'h0, 7'h00, 7'h00, '{4'h9, 6'h00, 1'b0, 3'h0, 1'b0}, 4'h9, 2'h0, 7'h00},
        '{4'h0, 4'h0, 2'h0, 2'h1, 7'h00, 7'h2a, '{4'h6, 6'h2a, 1'b1, 3'h5, 1'b1}, 4'h6, 2'h1, 7'h2a}};
    port_pin_ctrl u_port_pin_ctrl (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .alpha_dir_in(alpha_dir_in), .charlie_dir_in(charlie_dir_in),
        .delta_dir_in(delta_dir_in), .pullup_wr_in(pullup_wr_in),
        .port_alpha_pullup_select_in(alpha_sel), .charlie_pullup_select_in(charlie_sel),
        .delta_pullup_select_in(delta_sel), .func_wr_in(func_wr_in), .func_sel_in(func_sel_in),
        .reset_pin_in(pin_level), .internal_reset_in(internal_reset_in),
        .pullup_en_out(pullup_en_out), .alpha_pullup_sel_out(a_sel_out),
        .charlie_pullup_sel_out(c_sel_out), .delta_pullup_sel_out(d_sel_out),
        .func_sel_out(func_sel_out), .delta_periph_owned_out(delta_owned),
        .echo_sci_owned_out(echo_owned), .reset_pin_out(pin_out), .reset_pin_oe_out(pin_oe),
        .device_reset_out(dev_rst));
    board_model u_board_model (.drive_en_in(pin_oe), .drive_val_in(pin_out),
        .ext_low_in(ext_low), .pin_level_out(pin_level));
    // 25 ns system clock
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_neg(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // hang guard
    initial begin
        #(25 * 3000);
        miscompares++;
        end_of_test();
    end
    initial begin
        wait_neg(2);
        rst_b_in = 1'b1;
        foreach (rows[i]) begin
            {alpha_dir_in, alpha_sel, charlie_dir_in, charlie_sel} = rows[i][53:42];
            {delta_dir_in, delta_sel, func_sel_in} = rows[i][41:13];
            {pullup_wr_in, func_wr_in} = 2'h3;
            wait_neg(1);
            {pullup_wr_in, func_wr_in} = 2'h0;
            wait_neg(2);
            check(pullup_en_out, {rows[i].ea, 6'h00, rows[i].ec, rows[i].ed});
            check({a_sel_out, c_sel_out, d_sel_out}, {rows[i].sa, rows[i].sc, rows[i].sd});
            check(func_sel_out, rows[i].f);
            check(delta_owned, {rows[i].f.timer_select, {4{rows[i].f.spi_enable}}});
            check(echo_owned, {2{rows[i].f.sci_enable}});
            $display("row %0d done", i);
        end
        // synchronous reset clears the stored selections
        rst_b_in = 1'b0;
        wait_neg(2);
        check(dev_rst, 1'b1);
        check({a_sel_out, c_sel_out, d_sel_out}, 32'h0);
        rst_b_in = 1'b1;
        wait_neg(2);
        check(pullup_en_out, 32'h0);
        $display("reset test done");
        // internal source drives the pin low and the pin resets the device
        internal_reset_in = 1'b1;
        wait_neg(1);
        check({pin_oe, pin_out, pin_level}, 3'h4);
        wait_neg(5);
        check(dev_rst, 1'b1);
        internal_reset_in = 1'b0;
        wait_neg(6);
        check({pin_oe, dev_rst}, 2'h0);
        // board pulls the pin low
        ext_low = 1'b1;
        wait_neg(6);
        check({pin_oe, dev_rst}, 2'h1);
        ext_low = 1'b0;
        wait_neg(6);
        check(dev_rst, 1'b0);
        $display("reset pin test done");
        end_of_test();
    end
endmodule // tb
